// *** rtl/csbp_port.sv ***
// clocked serial bus port: one serial channel engine and the three-channel top
// assumes pins arrive asynchronously; software strobes are one-cycle pulses on i_clk
//
// Overview of operation
// - three independent channels, own clock and interrupt
// - mode bit picks plain or four-wire
// - plain mode characters are eight bits
// - four-wire characters are eight to sixteen bits
// - master clock is bus clock over 4..256
// - slave shifts only on external clock edges
// - transmit needs enable, pending data, no overrun
// - four-wire slave clocks only while select low
// - receive needs enable, no overrun; read restarts
// - four-wire master read starts only without transmit
// - overrun when character lands on full buffer
// - overrun blocks reception and transmission, master and slave
// - four-wire master: select low at start conflicts
// - four-wire slave: select high mid-frame conflicts
// - flags cleared by read then write zero
// - reading receive data clears receive full
// - tx done set on underrun, cleared by write
// - tx empty set on enable rise or load
// - interrupt sources per mode, conflict four-wire only
// - bit order, clock idle level, clock phase
// - plain mode ignores select pin and bidirectional
// - pulsed select drives only during a transfer
// - interrupt when any enabled flag is set
// - short characters sit at bit zero
module csbp_chan
    import csbp_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // configuration
    input wire logic i_four_wire_mode_select,
    input wire logic i_master_select,
    input wire logic i_tx_enable,
    input wire logic i_rx_enable,
    input wire logic [2:0] i_clk_div_sel,
    input wire logic [4:0] i_char_bits,
    input wire logic i_lsb_first,
    input wire logic i_clk_idle_high,
    input wire logic i_clk_phase,
    input wire logic i_bidir_select,
    input wire logic [1:0] i_chip_select_cfg,
    input wire logic i_idle_out_level,
    input wire logic [4:0] i_irq_enable,
    // software accesses
    input wire logic i_tx_write,
    input wire logic [15:0] i_tx_data,
    input wire logic i_rx_read,
    input wire logic i_status_read,
    input wire logic i_status_write,
    input wire logic [4:0] i_status_wdata,
    // status
    output logic [15:0] o_rx_data,
    output logic [4:0] o_status,
    output logic o_irq,
    // pins
    input wire logic i_serial_clock_pin,
    output logic o_serial_clock_pin,
    output logic o_serial_clock_pin_oe_n,
    input wire logic i_data_in_pin,
    output logic o_data_in_pin,
    output logic o_data_in_pin_oe_n,
    input wire logic i_data_out_pin,
    output logic o_data_out_pin,
    output logic o_data_out_pin_oe_n,
    input wire logic i_chip_select_pin,
    output logic o_chip_select_pin,
    output logic o_chip_select_pin_oe_n
);
    csbp_chan_t r;
    csbp_chan_t next_r;
    logic fw;
    logic mst;
    logic bidir;
    logic [2:0] sel;
    logic [7:0] half;
    logic [4:0] nb;
    logic ev;
    logic sl_edge;
    logic start;
    logic tx_go;
    logic rx_go;
    logic rx_bit;
    logic [4:0] idx;
    logic [4:0] clr;
    logic tx_on_sdi;
    logic rx_from_sdo;
    logic out_bit;
    logic cs_drive;

    always_comb begin
        next_r = r;
        fw = i_four_wire_mode_select;
        mst = i_master_select;
        // plain mode always standard wiring
        // bidir ignored
        bidir = fw & i_bidir_select;
        sel = (i_clk_div_sel > CSBP_DIV_SEL_MAX) ? CSBP_DIV_SEL_MAX : i_clk_div_sel;
        half = CSBP_HALF_BASE << sel;
        nb = CSBP_PLAIN_BITS;
        if (fw) begin
            if (i_char_bits < CSBP_MIN_BITS) begin
                nb = CSBP_MIN_BITS;
            end else if (i_char_bits > CSBP_MAX_BITS_5) begin
                nb = CSBP_MAX_BITS_5;
            end else begin
                nb = i_char_bits;
            end
        end
        tx_on_sdi = fw & ~bidir & ~mst;
        rx_from_sdo = fw & (bidir | ~mst);
        ev = 1'b0;
        start = 1'b0;
        idx = 5'h00;
        rx_bit = 1'b0;
        clr = 5'h00;
        out_bit = i_idle_out_level;
        cs_drive = 1'b0;

        // three-stage pin sync; a change counts once stages two and three agree
        next_r.s_sck = {r.s_sck[1:0], i_serial_clock_pin};
        next_r.s_sdi = {r.s_sdi[1:0], i_data_in_pin};
        next_r.s_sdo = {r.s_sdo[1:0], i_data_out_pin};
        next_r.s_cs = {r.s_cs[1:0], i_chip_select_pin};
        sl_edge = (r.s_sck[1] == r.s_sck[2]) && (r.s_sck[2] != r.f_sck);
        if (r.s_sck[1] == r.s_sck[2]) begin
            next_r.f_sck = r.s_sck[2];
        end
        if (r.s_sdi[1] == r.s_sdi[2]) begin
            next_r.f_sdi = r.s_sdi[2];
        end
        if (r.s_sdo[1] == r.s_sdo[2]) begin
            next_r.f_sdo = r.s_sdo[2];
        end
        if (r.s_cs[1] == r.s_cs[2]) begin
            next_r.f_cs = r.s_cs[2];
        end
        rx_bit = rx_from_sdo ? r.f_sdo : r.f_sdi;

        // software clears act first so that a same-cycle hardware set wins
        if (i_status_read) begin
            next_r.armed = r.flags;
        end
        if (i_status_write) begin
            clr = r.armed & ~i_status_wdata;
            next_r.armed = 5'h00;
        end
        if (i_rx_read) begin
            clr[CSBP_FL_RXF] = 1'b1;
        end
        if (i_tx_write) begin
            next_r.tx_buf = i_tx_data;
            clr[CSBP_FL_TXE] = 1'b1;
            clr[CSBP_FL_TX_DONE_FLAG] = 1'b1;
        end
        next_r.flags = r.flags & ~clr;

        next_r.te_d = i_tx_enable;
        if (i_tx_enable && !r.te_d) begin
            next_r.flags[CSBP_FL_TXE] = 1'b1;
        end

        if (i_rx_read && mst && i_rx_enable && !r.flags[CSBP_FL_OVR]
                && (!fw || !i_tx_enable)) begin
            next_r.rx_req = 1'b1;
        end

        tx_go = i_tx_enable & ~r.flags[CSBP_FL_TXE] & ~r.flags[CSBP_FL_OVR];
        rx_go = i_rx_enable & ~r.flags[CSBP_FL_OVR];

        if (!r.busy) begin
            if (mst) begin
                if (tx_go || (r.rx_req && rx_go)) begin
                    if (fw && !r.f_cs) begin
                        next_r.flags[CSBP_FL_CE] = 1'b1;
                    end else begin
                        start = 1'b1;
                    end
                end
            end else if (sl_edge && (r.s_sck[2] != i_clk_idle_high) && (!fw || !r.f_cs)) begin
                // slave starts on external edge, with select low in four-wire mode
                // only an edge leaving idle opens a frame: no false start after reset
                start = 1'b1;
            end
        end

        if (start) begin
            next_r.busy = 1'b1;
            next_r.is_tx = tx_go;
            next_r.is_rx = rx_go;
            next_r.rx_req = 1'b0;
            next_r.div = 8'h00;
            next_r.sck_lvl = 1'b0;
            next_r.edges = 6'h00;
            next_r.samp = 5'h00;
            next_r.oidx = 5'h00;
            next_r.nbits = nb;
            next_r.rx_sh = 16'h0000;
            next_r.tx_sh = r.tx_buf;
            if (tx_go) begin
                next_r.flags[CSBP_FL_TXE] = 1'b1;
            end
        end

        if (next_r.busy) begin
            if (mst) begin
                if (!start) begin
                    if (r.div == half - 8'h01) begin
                        next_r.div = 8'h00;
                        next_r.sck_lvl = ~r.sck_lvl;
                        ev = 1'b1;
                    end else begin
                        next_r.div = r.div + 8'h01;
                    end
                end
            end else if (fw && r.f_cs) begin
                next_r.flags[CSBP_FL_CE] = 1'b1;
                next_r.busy = 1'b0;
            end else begin
                ev = sl_edge;
            end
        end

        if (ev) begin
            next_r.edges = next_r.edges + 6'h01;
            if (next_r.edges[0] ^ i_clk_phase) begin
                if (next_r.is_rx) begin
                    if (i_lsb_first) begin
                        next_r.rx_sh[next_r.samp[3:0]] = rx_bit;
                    end else begin
                        next_r.rx_sh = {next_r.rx_sh[14:0], rx_bit};
                    end
                end
                next_r.samp = next_r.samp + 5'h01;
            end else if (next_r.samp != 5'h00) begin
                next_r.oidx = next_r.oidx + 5'h01;
            end
            if (next_r.edges == {next_r.nbits, 1'b0}) begin
                next_r.busy = 1'b0;
                if (next_r.is_rx) begin
                    if (next_r.flags[CSBP_FL_RXF]) begin
                        next_r.flags[CSBP_FL_OVR] = 1'b1;
                    end else begin
                        next_r.rx_data = next_r.rx_sh;
                        next_r.flags[CSBP_FL_RXF] = 1'b1;
                    end
                end
                if (next_r.is_tx && next_r.flags[CSBP_FL_TXE]) begin
                    next_r.flags[CSBP_FL_TX_DONE_FLAG] = 1'b1;
                end
            end
        end

        // data shown on the transmit pin; slave preloads first bit while waiting
        if (next_r.busy && next_r.is_tx) begin
            idx = i_lsb_first ? next_r.oidx : next_r.nbits - 5'h01 - next_r.oidx;
            out_bit = next_r.tx_sh[idx[3:0]];
        end else if (!next_r.busy && !mst && tx_go) begin
            idx = i_lsb_first ? 5'h00 : nb - 5'h01;
            out_bit = r.tx_buf[idx[3:0]];
        end

        next_r.sck_o = i_clk_idle_high ^ (next_r.busy & next_r.sck_lvl);
        next_r.sck_oe_n = ~mst;
        next_r.sdi_o = out_bit;
        next_r.sdo_o = out_bit;
        next_r.sdi_oe_n = ~(i_tx_enable & tx_on_sdi);
        next_r.sdo_oe_n = ~(i_tx_enable & ~tx_on_sdi);
        // select driven low only during master transfer
        cs_drive = fw & mst & next_r.busy & (i_chip_select_cfg == CSBP_CS_CFG_PULSED);
        next_r.cs_oe_n = ~cs_drive;

        next_r.irq = |(next_r.flags & i_irq_enable & {fw, 4'hf});
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            r <= '0;
            r.s_sck <= 3'h7;
            r.s_cs <= 3'h7;
            r.f_sck <= 1'b1;
            r.f_cs <= 1'b1;
            r.flags <= CSBP_FLAGS_RST;
            r.sck_oe_n <= 1'b1;
            r.sdi_oe_n <= 1'b1;
            r.sdo_oe_n <= 1'b1;
            r.cs_oe_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign o_rx_data = r.rx_data;
    assign o_status = r.flags;
    assign o_irq = r.irq;
    assign o_serial_clock_pin = r.sck_o;
    assign o_serial_clock_pin_oe_n = r.sck_oe_n;
    assign o_data_in_pin = r.sdi_o;
    assign o_data_in_pin_oe_n = r.sdi_oe_n;
    assign o_data_out_pin = r.sdo_o;
    assign o_data_out_pin_oe_n = r.sdo_oe_n;
    assign o_chip_select_pin = 1'b0;
    assign o_chip_select_pin_oe_n = r.cs_oe_n;
endmodule // csbp_chan

module csbp_port
    import csbp_pkg::*;
#(
    parameter int NCH = CSBP_NCH
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // per-channel configuration
    input wire logic [NCH-1:0] i_four_wire_mode_select,
    input wire logic [NCH-1:0] i_master_select,
    input wire logic [NCH-1:0] i_tx_enable,
    input wire logic [NCH-1:0] i_rx_enable,
    input wire logic [NCH-1:0][2:0] i_clk_div_sel,
    input wire logic [NCH-1:0][4:0] i_char_bits,
    input wire logic [NCH-1:0] i_lsb_first,
    input wire logic [NCH-1:0] i_clk_idle_high,
    input wire logic [NCH-1:0] i_clk_phase,
    input wire logic [NCH-1:0] i_bidir_select,
    input wire logic [NCH-1:0][1:0] i_chip_select_cfg,
    input wire logic [NCH-1:0] i_idle_out_level,
    input wire logic [NCH-1:0][4:0] i_irq_enable,
    // software accesses
    input wire logic [NCH-1:0] i_tx_write,
    input wire logic [NCH-1:0][15:0] i_tx_data,
    input wire logic [NCH-1:0] i_rx_read,
    input wire logic [NCH-1:0] i_status_read,
    input wire logic [NCH-1:0] i_status_write,
    input wire logic [NCH-1:0][4:0] i_status_wdata,
    // status
    output logic [NCH-1:0][15:0] o_rx_data,
    output logic [NCH-1:0][4:0] o_status,
    output logic [NCH-1:0] o_irq,
    // pins
    input wire logic [NCH-1:0] i_serial_clock_pin,
    output logic [NCH-1:0] o_serial_clock_pin,
    output logic [NCH-1:0] o_serial_clock_pin_oe_n,
    input wire logic [NCH-1:0] i_data_in_pin,
    output logic [NCH-1:0] o_data_in_pin,
    output logic [NCH-1:0] o_data_in_pin_oe_n,
    input wire logic [NCH-1:0] i_data_out_pin,
    output logic [NCH-1:0] o_data_out_pin,
    output logic [NCH-1:0] o_data_out_pin_oe_n,
    input wire logic [NCH-1:0] i_chip_select_pin,
    output logic [NCH-1:0] o_chip_select_pin,
    output logic [NCH-1:0] o_chip_select_pin_oe_n
);
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        csbp_chan u_chan (
            .i_clk(i_clk),
            .i_srst(i_srst),
            .i_four_wire_mode_select(i_four_wire_mode_select[c]),
            .i_master_select(i_master_select[c]),
            .i_tx_enable(i_tx_enable[c]),
            .i_rx_enable(i_rx_enable[c]),
            .i_clk_div_sel(i_clk_div_sel[c]),
            .i_char_bits(i_char_bits[c]),
            .i_lsb_first(i_lsb_first[c]),
            .i_clk_idle_high(i_clk_idle_high[c]),
            .i_clk_phase(i_clk_phase[c]),
            .i_bidir_select(i_bidir_select[c]),
            .i_chip_select_cfg(i_chip_select_cfg[c]),
            .i_idle_out_level(i_idle_out_level[c]),
            .i_irq_enable(i_irq_enable[c]),
            .i_tx_write(i_tx_write[c]),
            .i_tx_data(i_tx_data[c]),
            .i_rx_read(i_rx_read[c]),
            .i_status_read(i_status_read[c]),
            .i_status_write(i_status_write[c]),
            .i_status_wdata(i_status_wdata[c]),
            .o_rx_data(o_rx_data[c]),
            .o_status(o_status[c]),
            .o_irq(o_irq[c]),
            .i_serial_clock_pin(i_serial_clock_pin[c]),
            .o_serial_clock_pin(o_serial_clock_pin[c]),
            .o_serial_clock_pin_oe_n(o_serial_clock_pin_oe_n[c]),
            .i_data_in_pin(i_data_in_pin[c]),
            .o_data_in_pin(o_data_in_pin[c]),
            .o_data_in_pin_oe_n(o_data_in_pin_oe_n[c]),
            .i_data_out_pin(i_data_out_pin[c]),
            .o_data_out_pin(o_data_out_pin[c]),
            .o_data_out_pin_oe_n(o_data_out_pin_oe_n[c]),
            .i_chip_select_pin(i_chip_select_pin[c]),
            .o_chip_select_pin(o_chip_select_pin[c]),
            .o_chip_select_pin_oe_n(o_chip_select_pin_oe_n[c])
        );
    end
endmodule // csbp_port

// *** rtl/csbp_pkg.sv ***
// constants, flag layout and per-channel state for the clocked serial bus port
// assumes one 125 MHz bus clock and a synchronous active-high reset
package csbp_pkg;
    localparam int CSBP_NCH = 3;
    localparam int CSBP_MAX_BITS = 16;
    localparam logic [4:0] CSBP_PLAIN_BITS = 5'h08;
    localparam logic [4:0] CSBP_MIN_BITS = 5'h08;
    localparam logic [4:0] CSBP_MAX_BITS_5 = 5'h10;
    // flag positions in the status vector
    localparam int CSBP_FL_TXE = 0;
    localparam int CSBP_FL_TX_DONE_FLAG = 1;
    localparam int CSBP_FL_RXF = 2;
    localparam int CSBP_FL_OVR = 3;
    localparam int CSBP_FL_CE = 4;
    localparam int CSBP_NFLAGS = 5;
    // tx empty and tx done are set out of reset
    localparam logic [4:0] CSBP_FLAGS_RST = 5'h03;
    // master half period is 2 << select: ratios 4 to 256
    localparam logic [7:0] CSBP_HALF_BASE = 8'h02;
    localparam logic [2:0] CSBP_DIV_SEL_MAX = 3'h6;
    localparam logic [1:0] CSBP_CS_CFG_PULSED = 2'h3;

    typedef struct packed {
        logic [2:0] s_sck;
        logic [2:0] s_sdi;
        logic [2:0] s_sdo;
        logic [2:0] s_cs;
        logic f_sck;
        logic f_sdi;
        logic f_sdo;
        logic f_cs;
        logic te_d;
        logic busy;
        logic is_tx;
        logic is_rx;
        logic rx_req;
        logic [7:0] div;
        logic sck_lvl;
        logic [5:0] edges;
        logic [4:0] samp;
        logic [4:0] oidx;
        logic [4:0] nbits;
        logic [15:0] tx_buf;
        logic [15:0] tx_sh;
        logic [15:0] rx_sh;
        logic [15:0] rx_data;
        logic [4:0] flags;
        logic [4:0] armed;
        logic sck_o;
        logic sck_oe_n;
        logic sdi_o;
        logic sdi_oe_n;
        logic sdo_o;
        logic sdo_oe_n;
        logic cs_oe_n;
        logic irq;
    } csbp_chan_t;
endpackage

// *** test/csbp_port_assertions.sv ***
// checker: flag, divider and interrupt relations of every channel
// assumes it is bound into csbp_port and sees its ports only
module csbp_port_checker
    import csbp_pkg::*;
#(
    parameter int NCH = CSBP_NCH
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // configuration and strobes
    input wire logic [NCH-1:0] i_four_wire_mode_select,
    input wire logic [NCH-1:0] i_master_select,
    input wire logic [NCH-1:0][2:0] i_clk_div_sel,
    input wire logic [NCH-1:0][4:0] i_irq_enable,
    input wire logic [NCH-1:0] i_tx_write,
    input wire logic [NCH-1:0] i_rx_read,
    input wire logic [NCH-1:0] i_status_write,
    input wire logic [NCH-1:0][4:0] i_status_wdata,
    // watched outputs
    input wire logic [NCH-1:0][4:0] o_status,
    input wire logic [NCH-1:0] o_irq,
    input wire logic [NCH-1:0] o_serial_clock_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        logic [7:0] gap;
        logic [2:0] sel;
        assign sel = (i_clk_div_sel[c] > CSBP_DIV_SEL_MAX) ? CSBP_DIV_SEL_MAX : i_clk_div_sel[c];
        // cycles since the clock pin last moved, saturating
        always_ff @(posedge i_clk) begin
            if (i_srst) begin
                gap <= 8'hff;
            end else if ($changed(o_serial_clock_pin[c])) begin
                gap <= 8'h01;
            end else if (gap != 8'hff) begin
                gap <= gap + 8'h01;
            end
        end
        div_rate_a: assert property (i_master_select[c] && $changed(o_serial_clock_pin[c])
            |-> gap >= (CSBP_HALF_BASE << sel)) else $error("clock edge too early");
        ce_mode_a: assert property ($rose(o_status[c][CSBP_FL_CE])
            |-> i_four_wire_mode_select[c]) else $error("conflict flag in plain mode");
        tx_done_flag_clear_a: assert property (i_tx_write[c] |=> !o_status[c][CSBP_FL_TX_DONE_FLAG])
            else $error("tx done kept after write");
        txe_clear_a: assert property (i_tx_write[c] |=> !o_status[c][CSBP_FL_TXE])
            else $error("tx empty kept after write");
        rxf_clear_a: assert property (i_rx_read[c] |=> !o_status[c][CSBP_FL_RXF])
            else $error("rx full kept after read");
        flag_keep_a: assert property (i_status_write[c] && i_status_wdata[c] == 5'h1f
            && !i_tx_write[c] && !i_rx_read[c] |=> ($past(o_status[c]) & ~o_status[c]) == 5'h00)
            else $error("writing ones cleared a flag");
        ovr_cause_a: assert property ($rose(o_status[c][CSBP_FL_OVR])
            |-> $past(o_status[c][CSBP_FL_RXF])) else $error("overrun without full buffer");
        irq_level_a: assert property (($stable(o_status[c]) && $stable(i_irq_enable[c])) [*2]
            |-> o_irq[c] == |(o_status[c] & i_irq_enable[c])) else $error("bad interrupt level");
        ovr_block_a: assert property ((i_master_select[c] && o_status[c][CSBP_FL_OVR]) [*4]
            |-> !$changed(o_serial_clock_pin[c])) else $error("clock moved during overrun");
        ovr_c: cover property ($rose(o_status[c][CSBP_FL_OVR]));
        ce_c: cover property ($rose(o_status[c][CSBP_FL_CE]));
        rxf_c: cover property ($rose(o_status[c][CSBP_FL_RXF]));
    end
endmodule // csbp_port_checker

bind csbp_port csbp_port_checker #(.NCH(NCH)) u_chk (
    .i_clk(i_clk), .i_srst(i_srst), .i_four_wire_mode_select(i_four_wire_mode_select),
    .i_master_select(i_master_select), .i_clk_div_sel(i_clk_div_sel),
    .i_irq_enable(i_irq_enable), .i_tx_write(i_tx_write), .i_rx_read(i_rx_read),
    .i_status_write(i_status_write), .i_status_wdata(i_status_wdata), .o_status(o_status),
    .o_irq(o_irq), .o_serial_clock_pin(o_serial_clock_pin)
);

// *** test/csbp_slave_model.sv ***
// serial slave model on the pins of one master channel
// assumes idle-low clock, capture on rising and change on falling edges
module csbp_slave_model #(
    parameter int NB = 8
) (
    // wire levels
    input wire logic i_sck,
    input wire logic i_sdo,
    output logic o_sdi,
    // answer word and capture
    input wire logic [15:0] i_resp,
    output logic [15:0] o_got,
    output int o_frames
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] sh = 16'h0000;
    int cnt = 0;
    initial begin
        o_sdi = 1'b1;
        o_got = 16'h0000;
        o_frames = 0;
    end
    always @(posedge i_sck) begin
        sh = {sh[14:0], i_sdo};
        cnt++;
        if (cnt == NB) begin
            o_got = sh & ((16'h0001 << NB) - 16'h0001);
            cnt = 0;
            o_frames++;
        end
    end
    // first bit of the answer waits on the line while idle
    always @(negedge i_sck or i_resp) begin
        o_sdi = i_resp[NB-1-cnt];
    end
endmodule // csbp_slave_model

// *** test/csbp_port_tb.sv ***
// testbench: channels 0 (plain) and 1 (four-wire) as masters via strobes
// assumes a slave model on each of those channels' pins
module csbp_port_tb
    import csbp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic [2:0] mode = 3'h2;
    logic [2:0] ms = 3'h3;
    logic [2:0] te = 3'h0;
    logic [2:0] re = 3'h3;
    logic [2:0] lsb = 3'h2;
    logic [2:0] cs_tb = 3'h7;
    logic [2:0] cih = 3'h0;
    logic [2:0] iol = 3'h0;
    logic [2:0][1:0] csc = 6'h00;
    logic [2:0] txw = 3'h0;
    logic [2:0] rxr = 3'h0;
    logic [2:0] str = 3'h0;
    logic [2:0] stw = 3'h0;
    logic [2:0][2:0] sel = {3'h0, 3'h3, 3'h2};
    logic [2:0][4:0] cbits = {5'h08, 5'h0c, 5'h08};
    logic [2:0][4:0] ien = 15'h0000;
    logic [2:0][4:0] swd = 15'h0000;
    logic [2:0][15:0] txd = 48'h0;
    logic [1:0][15:0] resp = 32'h0;
    wire [2:0][15:0] rxd;
    wire [2:0][4:0] st;
    wire [2:0] irq, sck_o, sck_oe_n, din_o, din_oe_n, dout_o, dout_oe_n, cs_o, cs_oe_n;
    wire [2:0] din_w;
    wire [1:0][15:0] got;
    // released clock pulled low, released data pulled high
    wire [2:0] sck_w = sck_o & ~sck_oe_n;
    wire [2:0] dout_w = dout_o | dout_oe_n;
    wire [2:0] cs_w = cs_tb & (cs_o | cs_oe_n);
    int frames[2];
    int err_total = 0;
    int cmp_count = 0;
    assign din_w[2] = 1'b1;
    csbp_slave_model #(.NB(8)) u_sl0 (.i_sck(sck_w[0]), .i_sdo(dout_w[0]), .o_sdi(din_w[0]),
        .i_resp(resp[0]), .o_got(got[0]), .o_frames(frames[0]));
    csbp_slave_model #(.NB(12)) u_sl1 (.i_sck(sck_w[1]), .i_sdo(dout_w[1]), .o_sdi(din_w[1]),
        .i_resp(resp[1]), .o_got(got[1]), .o_frames(frames[1]));
    csbp_port DUT (
        .i_clk(i_clk), .i_srst(i_srst), .i_four_wire_mode_select(mode), .i_master_select(ms),
        .i_tx_enable(te), .i_rx_enable(re), .i_clk_div_sel(sel), .i_char_bits(cbits),
        .i_lsb_first(lsb), .i_clk_idle_high(cih), .i_clk_phase(3'h0), .i_bidir_select(3'h0),
        .i_chip_select_cfg(csc), .i_idle_out_level(iol), .i_irq_enable(ien),
        .i_tx_write(txw), .i_tx_data(txd), .i_rx_read(rxr), .i_status_read(str),
        .i_status_write(stw), .i_status_wdata(swd), .o_rx_data(rxd), .o_status(st), .o_irq(irq),
        .i_serial_clock_pin(sck_w), .o_serial_clock_pin(sck_o), .o_serial_clock_pin_oe_n(sck_oe_n),
        .i_data_in_pin(din_w), .o_data_in_pin(din_o), .o_data_in_pin_oe_n(din_oe_n),
        .i_data_out_pin(dout_w), .o_data_out_pin(dout_o), .o_data_out_pin_oe_n(dout_oe_n),
        .i_chip_select_pin(cs_w), .o_chip_select_pin(cs_o), .o_chip_select_pin_oe_n(cs_oe_n)
    );
    always #4 i_clk = ~i_clk;
    function automatic logic [15:0] rev12(input logic [15:0] v);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < 12; i++) r[i] = v[11-i];
        return r;
    endfunction
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // k: 0 tx write, 1 rx read, 2 status read, 3 status write
    task automatic sw(input int c, input int k, input logic [15:0] d);
        @(negedge i_clk);
        case (k)
            0: begin
                txw[c] = 1'b1;
                txd[c] = d;
            end
            1: rxr[c] = 1'b1;
            2: str[c] = 1'b1;
            default: begin
                stw[c] = 1'b1;
                swd[c] = d[4:0];
            end
        endcase
        @(negedge i_clk);
        txw[c] = 1'b0;
        rxr[c] = 1'b0;
        str[c] = 1'b0;
        stw[c] = 1'b0;
    endtask
    // bounded wait for a frame, then room for the flags to land
    task automatic wait_fr(input int c, input int n);
        int t;
        t = 0;
        while (frames[c] < n && t < 4000) begin
            @(negedge i_clk);
            t++;
        end
        chk(t < 4000, 1'b1);
        repeat (40) @(negedge i_clk);
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge i_clk);
        err_total++;
        results();
    end
    initial begin
        repeat (12) @(negedge i_clk);
        i_srst = 1'b0;
        @(negedge i_clk);
        chk(st[0], 5'h03);
        chk(irq, 3'h0);
        resp[0] = 16'h003c;
        sw(0, 0, 16'h00a5);
        chk(st[0][1:0], 2'h0);
        te[0] = 1'b1;
        repeat (2) @(negedge i_clk);
        chk(st[0][CSBP_FL_TXE], 1'b1);
        chk(dout_oe_n[0], 1'b0);
        wait_fr(0, 1);
        chk(got[0], 16'h00a5);
        chk(rxd[0], 16'h003c);
        chk(st[0], 5'h07);
        for (int k = 0; k < 5; k++) begin
            ien[0] = 5'h01 << k;
            repeat (3) @(negedge i_clk);
            chk(irq[0], k < 3);
        end
        // second character arrives on a full buffer
        resp[0] = 16'h00c3;
        sw(0, 0, 16'h005a);
        wait_fr(0, 2);
        chk(got[0], 16'h005a);
        chk(st[0][CSBP_FL_OVR], 1'b1);
        chk(rxd[0], 16'h003c);
        resp[0] = 16'h0096;
        sw(0, 0, 16'h0081);
        repeat (200) @(negedge i_clk);
        chk(frames[0], 2);
        chk(st[0][CSBP_FL_TXE], 1'b0);
        sw(0, 3, 16'h001f);
        sw(0, 3, 16'h0017);
        chk(st[0][CSBP_FL_OVR], 1'b1);
        sw(0, 1, 16'h0000);
        chk(st[0][CSBP_FL_RXF], 1'b0);
        sw(0, 2, 16'h0000);
        sw(0, 3, 16'h0017);
        wait_fr(0, 3);
        chk(got[0], 16'h0081);
        chk(rxd[0], 16'h0096);
        chk(st[0][CSBP_FL_OVR], 1'b0);
        te[0] = 1'b0;
        resp[0] = 16'h0069;
        sw(0, 1, 16'h0000);
        wait_fr(0, 4);
        chk(rxd[0], 16'h0069);
        // idle levels are changed only between frames
        iol[0] = 1'b1;
        cih[2] = 1'b1;
        repeat (3) @(negedge i_clk);
        chk(dout_o[0], 1'b1);
        chk(sck_o[2], 1'b1);
        // four-wire, twelve bits, lsb first
        resp[1] = 16'h0a53;
        te[1] = 1'b1;
        sw(1, 0, 16'h0c35);
        wait_fr(1, 1);
        chk(got[1], rev12(16'h0c35));
        chk(rxd[1], rev12(16'h0a53));
        csc[1] = 2'h2;
        @(negedge i_clk);
        csc[1] = 2'h3;
        te[1] = 1'b0;
        resp[1] = 16'h0123;
        sw(1, 1, 16'h0000);
        repeat (20) @(negedge i_clk);
        chk(cs_oe_n[1], 1'b0);
        wait_fr(1, 2);
        chk(cs_oe_n[1], 1'b1);
        chk(rxd[1], rev12(16'h0123));
        te[1] = 1'b1;
        sw(1, 1, 16'h0000);
        repeat (300) @(negedge i_clk);
        chk(frames[1], 2);
        cs_tb[1] = 1'b0;
        ien[1] = 5'h10;
        repeat (6) @(negedge i_clk);
        sw(1, 0, 16'h0fff);
        repeat (20) @(negedge i_clk);
        chk(st[1][CSBP_FL_CE], 1'b1);
        chk(irq[1], 1'b1);
        chk(frames[1], 2);
        results();
    end
endmodule // csbp_port_tb
